// File: include/pgpc_pkg.sv
// Purpose: shared constants, codes and helpers for the pulse-group phase-code timing block
// Assumes: one 50 MHz clock; the 10 us timing-standard tick is derived from it
// Notes:   all interval positions and delays are counted in 10 us ticks
//
// How it works
// - master groups use codes 0,0,180,180,0,180,0,180 and 0,180,180,0,0,0,0,0
// - all repetition timing comes from binary divider counters off the standard
// - interval counts run straight; any length change happens only at interval end
// - slave delays stay between 9200 us and period minus 9200 us
// - slew at speed 0 moves a delay 20000 us in no more than 60 seconds
// - slew either direction at one of five selectable speeds
// - station select picks master or one slave; only that one is slewed
// - a search that has not synchronised within 3 minutes is flagged
// - groundwave lock shown only while the guard sees nothing ahead of the pulse
// - blink warning raised while transmitter blinking makes readings unreliable
// - timing runs from 100 kc standard, phase-nudged only while afc_locked is high
// - slave groups have eight pulses, master groups nine, code on first eight
// - period is basic period minus specific index times 100 us
package pgpc_pkg;

   // ==========================================================
   // clocking and timing standard
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned STD_PERIOD_NS = 10000;   // 100 kc standard
   localparam int unsigned STD_DIV       = STD_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_US       = STD_PERIOD_NS / 1000;
   localparam int unsigned MS_TICKS      = 1000 / TICK_US;

   // ==========================================================
   // pulse group geometry, in ticks
   localparam int unsigned PULSE_SP_US    = 1000;
   localparam int unsigned MASTER9_US     = 9000;
   localparam int unsigned DLY_MIN_US     = 9200;
   localparam int unsigned SPEC_STEP_US   = 100;
   localparam logic [13:0] PULSE_SP_T     = 14'(PULSE_SP_US / TICK_US);
   localparam logic [13:0] MASTER9_T      = 14'(MASTER9_US / TICK_US);
   localparam logic [13:0] DLY_MIN_T      = 14'(DLY_MIN_US / TICK_US);
   localparam logic [13:0] GUARD_CHK_T    = 14'((MASTER9_US + PULSE_SP_US) / TICK_US);
   localparam logic [13:0] PERIOD_RST_T   = 14'h2710;
   localparam logic [13:0] DELAY_RST_T    = 14'h07D0;
   localparam int unsigned BASIC_US [6]   = '{100000, 80000, 60000, 50000, 40000, 30000};

   // ==========================================================
   // slew, search and monitors
   localparam int unsigned SLEW_SPAN_US   = 20000;
   localparam int unsigned SLEW_WIN_S     = 60;
   localparam logic [8:0]  SLEW_STEP_MS   = 9'(SLEW_WIN_S * 1000 * TICK_US / SLEW_SPAN_US);
   localparam logic [2:0]  SLEW_TOP_SPD   = 3'h4;   // five speeds, 0 fastest
   localparam int unsigned SEARCH_LIM_S   = 180;
   localparam int unsigned SEARCH_MS      = SEARCH_LIM_S * 1000;
   localparam logic [2:0]  GUARD_N        = 3'h4;
   localparam logic [1:0]  BLINK_N        = 2'h2;

   // ==========================================================
   // phase codes, bit i is pulse i+1, one is 180 degrees
   localparam logic [7:0]  CODE_MA = 8'hAC;
   localparam logic [7:0]  CODE_MB = 8'h06;
   localparam logic [7:0]  CODE_SA = 8'h60;
   localparam logic [7:0]  CODE_SB = 8'hCA;

   typedef enum logic [2:0] {
      SRCH_IDLE = 3'b001,
      SRCH_BUSY = 3'b010,
      SRCH_TOUT = 3'b100
   } pgpc_srch_t;

   function automatic logic [13:0] period_ticks(input logic [2:0] rate, input logic [2:0] spec);
      int unsigned r;
      r = (rate > 3'h5) ? 0 : int'(rate);
      return 14'(BASIC_US[r] / TICK_US - int'(spec) * (SPEC_STEP_US / TICK_US));
   endfunction : period_ticks

   function automatic logic code_bit(input logic slave, input logic grp_b, input logic [3:0] idx);
      logic [7:0] c;
      c = slave ? (grp_b ? CODE_SB : CODE_SA) : (grp_b ? CODE_MB : CODE_MA);
      return (idx > 4'h7) ? 1'b0 : c[idx[2:0]];
   endfunction : code_bit

endpackage : pgpc_pkg

// File: design/pgpc_std_div.sv
// Purpose: binary divider producing the 10 us timing-standard tick
// Assumes: nudges are one-cycle pulses from the carrier phase loop
// Notes:   a nudge stretches or shortens one tick period by one clock
`timescale 1ns/1ps
module pgpc_std_div #(
   parameter int unsigned DIV = pgpc_pkg::STD_DIV
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // phase steering
   input  wire logic lock,
   input  wire logic adv,
   input  wire logic ret,
   // tick out
   output logic      tick_q
);
   logic [9:0] cnt_q,  cnt_d;
   logic       adv_q,  adv_d;
   logic       ret_q,  ret_d;
   logic       tick_d;
   logic [9:0] last;
   logic       at_end;

   // ==========================================================
   // divider
   always_comb begin
      last = 10'(DIV - 1);
      if (ret_q && !adv_q) begin
         last = 10'(DIV);
      end else if (adv_q && !ret_q) begin
         last = 10'(DIV - 2);
      end
      at_end = (cnt_q >= last);
      cnt_d  = at_end ? 10'h000 : cnt_q + 10'h001;
      tick_d = at_end;
      // nudges only honoured once the standard follows the master carrier
      adv_d  = (lock && adv) || (adv_q && !at_end);
      ret_d  = (lock && ret) || (ret_q && !at_end);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q  <= 10'h000;
         adv_q  <= 1'b0;
         ret_q  <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         adv_q  <= adv_d;
         ret_q  <= ret_d;
         tick_q <= tick_d;
      end
   end

   // ==========================================================
   // checks
   logic [10:0] gap_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap_q <= 11'h000;
      end else begin
         gap_q <= tick_q ? 11'h001 : gap_q + 11'h001;
      end
   end

   property p_tick_gap;
      @(posedge clk) disable iff (!nrst)
      (tick_q && $past(tick_q, 1) == 1'b0 && gap_q > 11'h001)
         |-> (gap_q >= 11'(DIV - 1) && gap_q <= 11'(DIV + 1));
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("standard tick spacing wrong");

endmodule : pgpc_std_div

// File: design/pgpc_timing.sv
// Purpose: interval timing, pulse-group phase codes, slew, search and alarm flags
// Assumes: all inputs synchronous to clk; detector flags are levels
// Notes:   positions and delays count 10 us ticks from the master group start
`timescale 1ns/1ps
module pgpc_timing #(
   parameter int unsigned SEARCH_MS = pgpc_pkg::SEARCH_MS,
   parameter int unsigned STD_DIV   = pgpc_pkg::STD_DIV
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // rate selection
   input  wire logic [2:0]  rate_sel,
   input  wire logic [2:0]  spec_idx,
   // standard phase steering
   input  wire logic        afc_locked,
   input  wire logic        afc_adv,
   input  wire logic        afc_ret,
   // slew controls
   input  wire logic        slew_en,
   input  wire logic        slew_dir,
   input  wire logic [2:0]  slew_speed,
   input  wire logic [1:0]  station_sel,
   // search and detector flags
   input  wire logic        search_go,
   input  wire logic        sync_done,
   input  wire logic        guard_energy,
   input  wire logic        blink_detect,
   // timing outputs
   output logic             tick_q,
   output logic             interval_start_q,
   output logic             group_b_q,
   output logic             pulse_trig_q,
   output logic [1:0]       station_q,
   output logic [3:0]       pulse_idx_q,
   output logic             phase_code_q,
   // delays
   output logic [13:0]      delay_x_q,
   output logic [13:0]      delay_y_q,
   output logic [13:0]      delay_z_q,
   // status
   output logic             search_busy_q,
   output logic             search_timeout_q,
   output logic             ground_lock_q,
   output logic             blink_warn_q
);
   // ==========================================================
   // timing standard
   pgpc_std_div #(.DIV(STD_DIV)) u_div (
      .clk    (clk),
      .nrst   (nrst),
      .lock   (afc_locked),
      .adv    (afc_adv),
      .ret    (afc_ret),
      .tick_q (tick_q)
   );

   function automatic logic [4:0] pulse_hit(input logic [13:0] off, input logic master);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 8; i++) begin
         if (off == 14'(i * int'(pgpc_pkg::PULSE_SP_T))) begin
            r = {1'b1, 4'(i)};
         end
      end
      if (master && off == pgpc_pkg::MASTER9_T) begin
         r = 5'h18;
      end
      return r;
   endfunction : pulse_hit

   // ==========================================================
   // interval counter
   logic [13:0] pos_q,    pos_d;
   logic [13:0] period_q, period_d;
   logic [1:0]  madj_q,   madj_d;
   logic [6:0]  ms_q,     ms_d;
   logic        grp_d,    istart_d;
   logic [13:0] end_cnt;
   logic        wrap, ms_tick, slew_step;

   always_comb begin
      end_cnt  = period_q - 14'h0001 + {13'h0000, madj_q[0]} - {13'h0000, madj_q[1]};
      wrap     = tick_q && (pos_q >= end_cnt);
      ms_tick  = tick_q && (ms_q == 7'(pgpc_pkg::MS_TICKS - 1));
      pos_d    = pos_q;
      period_d = period_q;
      grp_d    = group_b_q;
      istart_d = 1'b0;
      ms_d     = ms_tick ? 7'h00 : (tick_q ? ms_q + 7'h01 : ms_q);
      if (wrap) begin
         pos_d    = 14'h0000;
         period_d = pgpc_pkg::period_ticks(rate_sel, spec_idx);
         grp_d    = ~group_b_q;
         istart_d = 1'b1;
      end else if (tick_q) begin
         pos_d    = pos_q + 14'h0001;
      end
      // master slew lengthens or shortens one interval at its end only
      madj_d = wrap ? 2'h0 : madj_q;
      if (slew_step && station_sel == 2'h0) begin
         madj_d = slew_dir ? 2'h1 : 2'h2;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pos_q            <= 14'h0000;
         period_q         <= pgpc_pkg::PERIOD_RST_T;
         madj_q           <= 2'h0;
         ms_q             <= 7'h00;
         group_b_q        <= 1'b0;
         interval_start_q <= 1'b0;
      end else begin
         pos_q            <= pos_d;
         period_q         <= period_d;
         madj_q           <= madj_d;
         ms_q             <= ms_d;
         group_b_q        <= grp_d;
         interval_start_q <= istart_d;
      end
   end

   // ==========================================================
   // slew rate and slave delays
   logic [8:0]  slew_ms_q, slew_ms_d;
   logic [8:0]  step_len;
   logic [2:0]  spd;
   logic [13:0] dly_q [3];
   logic [13:0] dly_d [3];
   logic [13:0] dly_max;

   always_comb begin
      spd       = (slew_speed > pgpc_pkg::SLEW_TOP_SPD) ? pgpc_pkg::SLEW_TOP_SPD : slew_speed;
      step_len  = pgpc_pkg::SLEW_STEP_MS << spd;
      slew_step = slew_en && ms_tick && (slew_ms_q >= step_len - 9'h001);
      if (!slew_en) begin
         slew_ms_d = 9'h000;
      end else if (ms_tick) begin
         slew_ms_d = slew_step ? 9'h000 : slew_ms_q + 9'h001;
      end else begin
         slew_ms_d = slew_ms_q;
      end
      dly_max = period_q - pgpc_pkg::DLY_MIN_T;
      for (int k = 0; k < 3; k++) begin
         dly_d[k] = dly_q[k];
         if (slew_step && station_sel == 2'(k + 1)) begin
            dly_d[k] = slew_dir ? dly_q[k] + 14'h0001 : dly_q[k] - 14'h0001;
         end
         // clamp keeps the group clear of the master group at both ends
         if (dly_d[k] < pgpc_pkg::DLY_MIN_T) begin
            dly_d[k] = pgpc_pkg::DLY_MIN_T;
         end else if (dly_d[k] > dly_max) begin
            dly_d[k] = dly_max;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slew_ms_q <= 9'h000;
         dly_q     <= '{pgpc_pkg::DELAY_RST_T, pgpc_pkg::DELAY_RST_T, pgpc_pkg::DELAY_RST_T};
      end else begin
         slew_ms_q <= slew_ms_d;
         dly_q     <= dly_d;
      end
   end

   assign delay_x_q = dly_q[0];
   assign delay_y_q = dly_q[1];
   assign delay_z_q = dly_q[2];

   // ==========================================================
   // pulse triggers and phase code
   logic       trig_d, code_d;
   logic [1:0] st_d;
   logic [3:0] idx_d;
   logic [4:0] hit;

   always_comb begin
      trig_d = 1'b0;
      st_d   = station_q;
      idx_d  = pulse_idx_q;
      code_d = phase_code_q;
      hit    = pulse_hit(pos_q, 1'b1);
      // overlapping groups resolve master first, then x, y, z
      if (hit[4]) begin
         st_d = 2'h0;
      end else begin
         for (int k = 2; k >= 0; k--) begin
            if (pulse_hit(pos_q - dly_q[k], 1'b0) != 5'h00) begin
               hit  = pulse_hit(pos_q - dly_q[k], 1'b0);
               st_d = 2'(k + 1);
            end
         end
      end
      if (tick_q && hit[4]) begin
         trig_d = 1'b1;
         idx_d  = hit[3:0];
         code_d = pgpc_pkg::code_bit(st_d != 2'h0, group_b_q, hit[3:0]);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pulse_trig_q <= 1'b0;
         station_q    <= 2'h0;
         pulse_idx_q  <= 4'h0;
         phase_code_q <= 1'b0;
      end else begin
         pulse_trig_q <= trig_d;
         station_q    <= st_d;
         pulse_idx_q  <= idx_d;
         phase_code_q <= code_d;
      end
   end

   // ==========================================================
   // search timeout, guard and blink
   pgpc_pkg::pgpc_srch_t srch_q, srch_d;
   logic [17:0] srch_ms_q, srch_ms_d;
   logic [2:0]  gcnt_q,    gcnt_d;
   logic [1:0]  bcnt_q,    bcnt_d;
   logic        glock_d,   bwarn_d, gchk;

   always_comb begin
      srch_d    = srch_q;
      srch_ms_d = (srch_q == pgpc_pkg::SRCH_BUSY && ms_tick) ? srch_ms_q + 18'h00001 : srch_ms_q;
      unique case (srch_q)
         pgpc_pkg::SRCH_IDLE, pgpc_pkg::SRCH_TOUT: begin
            if (search_go) begin
               srch_d    = pgpc_pkg::SRCH_BUSY;
               srch_ms_d = 18'h00000;
            end
         end
         pgpc_pkg::SRCH_BUSY: begin
            if (sync_done) begin
               srch_d = pgpc_pkg::SRCH_IDLE;
            end else if (ms_tick && srch_ms_q >= 18'(SEARCH_MS - 1)) begin
               srch_d = pgpc_pkg::SRCH_TOUT;
            end
         end
         default: srch_d = pgpc_pkg::SRCH_IDLE;
      endcase
      // only presence ahead of the pulse counts, so amplitude ratio does not matter
      gchk    = tick_q && pos_q == pgpc_pkg::GUARD_CHK_T;
      gcnt_d  = gcnt_q;
      glock_d = ground_lock_q;
      if (gchk) begin
         if (!sync_done || guard_energy) begin
            gcnt_d  = 3'h0;
            glock_d = 1'b0;
         end else if (gcnt_q < pgpc_pkg::GUARD_N) begin
            gcnt_d  = gcnt_q + 3'h1;
            glock_d = (gcnt_q + 3'h1 == pgpc_pkg::GUARD_N);
         end
      end
      bcnt_d  = bcnt_q;
      bwarn_d = blink_warn_q;
      if (wrap) begin
         if (!blink_detect) begin
            bcnt_d  = 2'h0;
            bwarn_d = 1'b0;
         end else if (bcnt_q < pgpc_pkg::BLINK_N) begin
            bcnt_d  = bcnt_q + 2'h1;
            bwarn_d = (bcnt_q + 2'h1 == pgpc_pkg::BLINK_N);
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         srch_q        <= pgpc_pkg::SRCH_IDLE;
         srch_ms_q     <= 18'h00000;
         gcnt_q        <= 3'h0;
         bcnt_q        <= 2'h0;
         ground_lock_q <= 1'b0;
         blink_warn_q  <= 1'b0;
      end else begin
         srch_q        <= srch_d;
         srch_ms_q     <= srch_ms_d;
         gcnt_q        <= gcnt_d;
         bcnt_q        <= bcnt_d;
         ground_lock_q <= glock_d;
         blink_warn_q  <= bwarn_d;
      end
   end

   assign search_busy_q    = srch_q[1];
   assign search_timeout_q = srch_q[2];

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_code_master;
      pulse_trig_q && station_q == 2'h0 && pulse_idx_q < 4'h8
         |-> phase_code_q == (group_b_q ? pgpc_pkg::CODE_MB[pulse_idx_q[2:0]]
                                        : pgpc_pkg::CODE_MA[pulse_idx_q[2:0]]);
   endproperty
   a_code_master: assert property (p_code_master) else $error("master code wrong");

   property p_code_slave;
      pulse_trig_q && station_q != 2'h0
         |-> phase_code_q == (group_b_q ? pgpc_pkg::CODE_SB[pulse_idx_q[2:0]]
                                        : pgpc_pkg::CODE_SA[pulse_idx_q[2:0]]);
   endproperty
   a_code_slave: assert property (p_code_slave) else $error("slave code wrong");

   property p_pos_step;
      tick_q && !wrap |=> pos_q == $past(pos_q) + 14'h0001;
   endproperty
   a_pos_step: assert property (p_pos_step) else $error("interval count skipped");

   property p_dly_range;
      $stable(period_q) |-> delay_y_q >= pgpc_pkg::DLY_MIN_T && delay_y_q <= dly_max;
   endproperty
   a_dly_range: assert property (p_dly_range) else $error("delay out of range");

   property p_slew_len;
      slew_step |-> slew_ms_q <= 9'h1DF && $past(slew_en);
   endproperty
   a_slew_len: assert property (p_slew_len) else $error("slew step too slow");

   property p_slew_only_sel;
      !(slew_step && station_sel == 2'h1) && $stable(period_q) |=> $stable(delay_x_q);
   endproperty
   a_slew_only_sel: assert property (p_slew_only_sel) else $error("unselected delay moved");

   property p_timeout;
      srch_q == pgpc_pkg::SRCH_BUSY && !sync_done && ms_tick
         && srch_ms_q == 18'(SEARCH_MS - 1) |=> search_timeout_q && !search_busy_q;
   endproperty
   a_timeout: assert property (p_timeout) else $error("search timeout missed");

   property p_guard_drop;
      gchk && guard_energy |=> !ground_lock_q;
   endproperty
   a_guard_drop: assert property (p_guard_drop) else $error("lock kept with guard energy");

   property p_blink;
      wrap && blink_detect && bcnt_q == 2'h1 |=> blink_warn_q;
   endproperty
   a_blink: assert property (p_blink) else $error("blink warning missed");

   property p_slave_eight;
      pulse_trig_q && station_q != 2'h0 |-> pulse_idx_q < 4'h8;
   endproperty
   a_slave_eight: assert property (p_slave_eight) else $error("slave ninth pulse");

   property p_alternate;
      interval_start_q |-> group_b_q != $past(group_b_q);
   endproperty
   a_alternate: assert property (p_alternate) else $error("code group not alternated");

   c_master9:  cover property (pulse_trig_q && station_q == 2'h0 && pulse_idx_q == 4'h8);
   c_slave:    cover property (pulse_trig_q && station_q == 2'h3);
   c_timeout:  cover property (search_timeout_q);
   c_glock:    cover property (ground_lock_q);

endmodule : pgpc_timing

// File: dv/pgpc_det_model.sv
// Purpose: detector stand-in for the timing block
// Assumes: bench commands change at the falling edge
// Notes:   flags are levels, as the detector holds them
`timescale 1ns/1ps
module pgpc_det_model (
   // clock
   input  wire logic clk,
   // bench commands
   input  wire logic want_sync,
   input  wire logic sky,
   input  wire logic blink,
   // detector flags
   output logic      sync_done,
   output logic      guard_energy,
   output logic      blink_detect
);
   // ==========================================================
   // flags move off the sampling edge so no race with the block
   initial {sync_done, guard_energy, blink_detect} = 3'h0;
   always @(negedge clk) begin
      sync_done    <= want_sync;
      guard_energy <= sky;
      blink_detect <= blink;
   end
endmodule : pgpc_det_model

// File: dv/pulse_group_phase_code_timing_test.sv
// Purpose: self-checking bench for pgpc_timing
// Assumes: divider shortened to 2 clk a tick, search limit 5 ms
// Notes:   pulse notes are queued ahead and popped as triggers appear
`timescale 1ns/1ps
module pulse_group_phase_code_timing_test;
   localparam int unsigned DIV = 2;
   localparam logic [7:0]  MC [2] = '{8'hAC, 8'h06};
   localparam logic [7:0]  SC [2] = '{8'h60, 8'hCA};
   logic        clk, nrst, adv, ret, slew_en, slew_dir, go, want_sync, sky, blink, watch, lock;
   logic        sync_done, guard_energy, blink_detect, exp_grp;
   logic        tick_q, start_q, grp_q, trig_q, code_q, busy_q, tout_q, lock_q, warn_q;
   logic [1:0]  sel, stn_q;
   logic [2:0]  rate, spec, speed;
   logic [3:0]  idx_q;
   logic [13:0] dx, dy, dz, want_per;
   logic [15:0] rs = 16'h970D;
   logic [20:0] notes[$];
   int          num_errors, n_tests, tcnt;

   pgpc_det_model pgpc_det_model_i (.clk(clk), .want_sync(want_sync), .sky(sky),
      .blink(blink), .sync_done(sync_done), .guard_energy(guard_energy),
      .blink_detect(blink_detect));

   pgpc_timing #(.SEARCH_MS(5), .STD_DIV(DIV)) pgpc_timing_i (.clk(clk), .nrst(nrst),
      .rate_sel(rate), .spec_idx(spec), .afc_locked(lock), .afc_adv(adv), .afc_ret(ret),
      .slew_en(slew_en), .slew_dir(slew_dir), .slew_speed(speed), .station_sel(sel),
      .search_go(go), .sync_done(sync_done), .guard_energy(guard_energy),
      .blink_detect(blink_detect), .tick_q(tick_q), .interval_start_q(start_q),
      .group_b_q(grp_q), .pulse_trig_q(trig_q), .station_q(stn_q), .pulse_idx_q(idx_q),
      .phase_code_q(code_q), .delay_x_q(dx), .delay_y_q(dy), .delay_z_q(dz),
      .search_busy_q(busy_q), .search_timeout_q(tout_q), .ground_lock_q(lock_q),
      .blink_warn_q(warn_q));

   // ==========================================================
   // helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic plan_group(input int b);
      for (int n = 0; n < 9; n++)
         notes.push_back({2'h0, 4'(n), (n < 8) ? MC[b][n] : 1'b0, 14'((n < 8) ? n * 100 : 900)});
      for (int n = 0; n < 8; n++)
         notes.push_back({2'h1, 4'(n), SC[b][n], 14'(2000 + n * 100)});
   endtask : plan_group

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // ==========================================================
   // clock, afc nudges from the lfsr (refused until lock rises), watchdog
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(negedge clk) begin
      rs = lfsr(rs);
      adv <= rs[0] & rs[5];
      ret <= rs[3] & rs[9];
   end

   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      $display("timeout");
      wrap_up();
   end

   // ==========================================================
   // monitor: tick position, pulse notes, interval length and group
   always @(posedge clk) begin
      if (!nrst)
         tcnt = 0;
      if (tick_q)
         tcnt++;
      if (trig_q && watch) begin
         if (notes.size() == 0)
            check(32'h1, 32'h0);
         else
            check({stn_q, idx_q, code_q, 14'(tcnt - 1)}, notes.pop_front());
      end
      if (start_q) begin
         exp_grp = ~exp_grp;
         check({grp_q, 14'(tcnt)}, {exp_grp, want_per});
         want_per = 14'(30000 / 10 - 7 * 100 / 10);
         tcnt = 0;
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      nrst = 1'b0;
      {adv, ret, slew_en, slew_dir, go, sky, blink, exp_grp, sel, lock} = '0;
      {rate, spec, speed, want_sync} = {3'h5, 3'h7, 3'h0, 1'b1};
      want_per = 14'h2710;
      plan_group(0);
      plan_group(1);
      watch = 1'b1;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      @(posedge clk iff start_q);
      @(posedge clk iff start_q);
      @(negedge clk);
      watch = 1'b0;
      check(notes.size(), 0);
      $display("test pulse groups done");
      {sel, slew_dir, slew_en, blink} = {2'h2, 1'b1, 1'b1, 1'b1};
      repeat (35 * 100 * DIV) @(negedge clk);
      slew_en = 1'b0;
      check({dx, dy, dz}, {14'h7D0, 14'h7D1, 14'h7D0});
      // one edge with slew_en low so the step count restarts
      @(negedge clk);
      {slew_dir, slew_en} = 2'b01;
      repeat (35 * 100 * DIV) @(negedge clk);
      slew_en = 1'b0;
      check({dx, dy, dz}, {14'h7D0, 14'h7D0, 14'h7D0});
      @(negedge clk);
      // second speed steps every 60 ms, so nothing moves by 35 ms
      {sel, slew_dir, speed, slew_en} = {2'h3, 1'b1, 3'h1, 1'b1};
      repeat (35 * 100 * DIV) @(negedge clk);
      check(dz, 14'h7D0);
      repeat (30 * 100 * DIV) @(negedge clk);
      slew_en = 1'b0;
      check({dx, dy, dz}, {14'h7D0, 14'h7D0, 14'h7D1});
      $display("test slew done");
      check({lock_q, warn_q}, 2'b11);
      {sky, blink} = 2'b10;
      // guard and blink are only looked at once per interval
      repeat ((int'(want_per) + 8) * DIV) @(negedge clk);
      check({lock_q, warn_q}, 2'b00);
      $display("test lock and blink done");
      // lfsr nudges now reach the standard; the wide margins absorb them
      {want_sync, go, lock} = 3'b011;
      @(negedge clk);
      go = 1'b0;
      repeat (250 * DIV) @(negedge clk);
      check({busy_q, tout_q}, 2'b10);
      repeat (450 * DIV) @(negedge clk);
      check(tout_q, 1);
      {want_sync, go} = 2'b11;
      @(negedge clk);
      go = 1'b0;
      repeat (4) @(negedge clk);
      check({busy_q, tout_q}, 2'b00);
      $display("test search done");
      wrap_up();
   end
endmodule : pulse_group_phase_code_timing_test
